// ### iac_pkg.sv
// Constants, field positions and carrier types for the two-wire address and bit-rate block.
// Assumes a single 40 MHz clock and an AXI4-Lite register master.
package iac_pkg;

  localparam int unsigned CLK_HZ      = 40_000_000;
  localparam int unsigned SYNC_STAGES = 3;

  localparam int unsigned AW = 4;
  localparam logic [AW-1:0] OFS_OWN_ADDR = 4'h0;
  localparam logic [AW-1:0] OFS_DIV      = 4'h4;
  localparam logic [AW-1:0] OFS_CMD      = 4'h8;
  localparam logic [AW-1:0] OFS_STATUS   = 4'hc;

  localparam logic [7:0] RST_OWN_ADDR = 8'h00;
  localparam logic [7:0] RST_DIV      = 8'h00;
  localparam logic [7:0] RST_CMD_DATA = 8'h00;

  localparam int unsigned ADDR_HI   = 7;
  localparam int unsigned ADDR_LO   = 1;
  localparam int unsigned FACTOR_HI = 7;
  localparam int unsigned FACTOR_LO = 6;
  localparam int unsigned CODE_HI   = 5;
  localparam int unsigned CMD_START = 8;
  localparam int unsigned CMD_STOP  = 9;
  localparam int unsigned CMD_SEND  = 10;
  localparam int unsigned ST_BUSY   = 0;
  localparam int unsigned ST_ACK    = 1;
  localparam int unsigned ST_SCL    = 2;
  localparam int unsigned ST_SDA    = 3;
  localparam int unsigned ST_MATCH  = 4;
  localparam int unsigned ACK_BIT   = 8;
  localparam int unsigned MIN_DIV   = 20;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [11:0] div;
    logic [9:0]  sda;
    logic [10:0] start;
    logic [10:0] stop;
  } iac_timing_t;

  typedef struct packed {
    logic [15:0] half;
    logic [15:0] sda;
    logic [15:0] start;
    logic [15:0] stop;
  } iac_cycles_t;

  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_LOW, ST_HIGH, ST_HOLD} iac_state_t;
  typedef enum logic [1:0] {PUR_BIT, PUR_STOP, PUR_RSTART} iac_purpose_t;

endpackage : iac_pkg

// ### iac_top.sv
// Own slave address, bit-rate divider and a small bus timing engine, behind AXI4-Lite.
// Assumes open-drain pads outside; pins arrive unsynchronised.
//
// Our own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module iac_top
  import iac_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [iac_pkg::AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [iac_pkg::AW-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [9:0]        rx_addr,
  input  wire logic              rx_ten_bit,
  output logic                   addr_match,
  input  wire logic              scl_i,
  output logic                   scl_o,
  output logic                   scl_oe,
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe
);
  import iac_pkg::*;

  logic [7:0]     own_addr_q;
  logic [7:0]     div_q;
  logic [7:0]     cmd_data_q;
  logic           aw_have_q;
  logic           w_have_q;
  logic [AW-1:0]  aw_addr_q;
  logic [31:0]    w_data_q;
  logic [3:0]     w_strb_q;
  logic           wr_fire;
  logic           go_start;
  logic           go_stop;
  logic           go_send;
  logic [2:0]     scl_sync_q;
  logic [2:0]     sda_sync_q;
  logic           scl_s_q;
  logic           sda_s_q;
  iac_state_t     state_q;
  iac_purpose_t   pur_q;
  logic [15:0]    cnt_q;
  logic [8:0]     shift_q;
  logic [3:0]     bit_q;
  logic           ack_q;
  logic           scl_oe_q;
  logic           sda_oe_q;
  logic           match_q;
  logic [1:0]     mul_sh;
  iac_timing_t    tim;
  iac_cycles_t    cyc;
  logic [15:0]    high_tgt;

  function automatic iac_timing_t lut(input logic [5:0] c);
    case (c)
      6'h00: lut = '{12'd20, 10'd7, 11'd6, 11'd11};
      6'h01: lut = '{12'd22, 10'd7, 11'd7, 11'd12};
      6'h02: lut = '{12'd24, 10'd8, 11'd8, 11'd13};
      6'h03: lut = '{12'd26, 10'd8, 11'd9, 11'd14};
      6'h04: lut = '{12'd28, 10'd9, 11'd10, 11'd15};
      6'h05: lut = '{12'd30, 10'd9, 11'd11, 11'd16};
      6'h06: lut = '{12'd34, 10'd10, 11'd13, 11'd18};
      6'h07: lut = '{12'd40, 10'd10, 11'd16, 11'd21};
      6'h08: lut = '{12'd28, 10'd7, 11'd10, 11'd15};
      6'h09: lut = '{12'd32, 10'd7, 11'd12, 11'd17};
      6'h0a: lut = '{12'd36, 10'd9, 11'd14, 11'd19};
      6'h0b: lut = '{12'd40, 10'd9, 11'd16, 11'd21};
      6'h0c: lut = '{12'd44, 10'd11, 11'd18, 11'd23};
      6'h0d: lut = '{12'd48, 10'd11, 11'd20, 11'd25};
      6'h0e: lut = '{12'd56, 10'd13, 11'd24, 11'd29};
      6'h0f: lut = '{12'd68, 10'd13, 11'd30, 11'd35};
      6'h10: lut = '{12'd48, 10'd9, 11'd18, 11'd25};
      6'h11: lut = '{12'd56, 10'd9, 11'd22, 11'd29};
      6'h12: lut = '{12'd64, 10'd13, 11'd26, 11'd33};
      6'h13: lut = '{12'd72, 10'd13, 11'd30, 11'd37};
      6'h14: lut = '{12'd80, 10'd17, 11'd34, 11'd41};
      6'h15: lut = '{12'd88, 10'd17, 11'd38, 11'd45};
      6'h16: lut = '{12'd104, 10'd21, 11'd46, 11'd53};
      6'h17: lut = '{12'd128, 10'd21, 11'd58, 11'd65};
      6'h18: lut = '{12'd80, 10'd9, 11'd38, 11'd41};
      6'h19: lut = '{12'd96, 10'd9, 11'd46, 11'd49};
      6'h1a: lut = '{12'd112, 10'd17, 11'd54, 11'd57};
      6'h1b: lut = '{12'd128, 10'd17, 11'd62, 11'd65};
      6'h1c: lut = '{12'd144, 10'd25, 11'd70, 11'd73};
      6'h1d: lut = '{12'd160, 10'd25, 11'd78, 11'd81};
      6'h1e: lut = '{12'd192, 10'd33, 11'd94, 11'd97};
      6'h1f: lut = '{12'd240, 10'd33, 11'd118, 11'd121};
      6'h20: lut = '{12'd160, 10'd17, 11'd78, 11'd81};
      6'h21: lut = '{12'd192, 10'd17, 11'd94, 11'd97};
      6'h22: lut = '{12'd224, 10'd33, 11'd110, 11'd113};
      6'h23: lut = '{12'd256, 10'd33, 11'd126, 11'd129};
      6'h24: lut = '{12'd288, 10'd49, 11'd142, 11'd145};
      6'h25: lut = '{12'd320, 10'd49, 11'd158, 11'd161};
      6'h26: lut = '{12'd384, 10'd65, 11'd190, 11'd193};
      6'h27: lut = '{12'd480, 10'd65, 11'd238, 11'd241};
      6'h28: lut = '{12'd320, 10'd33, 11'd158, 11'd161};
      6'h29: lut = '{12'd384, 10'd33, 11'd190, 11'd193};
      6'h2a: lut = '{12'd448, 10'd65, 11'd222, 11'd225};
      6'h2b: lut = '{12'd512, 10'd65, 11'd254, 11'd257};
      6'h2c: lut = '{12'd576, 10'd97, 11'd286, 11'd289};
      6'h2d: lut = '{12'd640, 10'd97, 11'd318, 11'd321};
      6'h2e: lut = '{12'd768, 10'd129, 11'd382, 11'd385};
      6'h2f: lut = '{12'd960, 10'd129, 11'd478, 11'd481};
      6'h30: lut = '{12'd640, 10'd65, 11'd318, 11'd321};
      6'h31: lut = '{12'd768, 10'd65, 11'd382, 11'd385};
      6'h32: lut = '{12'd896, 10'd129, 11'd446, 11'd449};
      6'h33: lut = '{12'd1024, 10'd129, 11'd510, 11'd513};
      6'h34: lut = '{12'd1152, 10'd193, 11'd574, 11'd577};
      6'h35: lut = '{12'd1280, 10'd193, 11'd638, 11'd641};
      6'h36: lut = '{12'd1536, 10'd257, 11'd766, 11'd769};
      6'h37: lut = '{12'd1920, 10'd257, 11'd958, 11'd961};
      6'h38: lut = '{12'd1280, 10'd129, 11'd638, 11'd641};
      6'h39: lut = '{12'd1536, 10'd129, 11'd766, 11'd769};
      6'h3a: lut = '{12'd1792, 10'd257, 11'd894, 11'd897};
      6'h3b: lut = '{12'd2048, 10'd257, 11'd1022, 11'd1025};
      6'h3c: lut = '{12'd2304, 10'd385, 11'd1150, 11'd1153};
      6'h3d: lut = '{12'd2560, 10'd385, 11'd1278, 11'd1281};
      6'h3e: lut = '{12'd3072, 10'd513, 11'd1534, 11'd1537};
      default: lut = '{12'd3840, 10'd513, 11'd1918, 11'd1921};
    endcase
  endfunction : lut

  // Reserved multiplier code behaves as factor one, so timing never stalls
  always_comb begin
    unique case (div_q[FACTOR_HI:FACTOR_LO])
      2'b01:   mul_sh = 2'd1;
      2'b10:   mul_sh = 2'd2;
      default: mul_sh = 2'd0;
    endcase
  end

  assign tim       = lut(div_q[CODE_HI:0]);
  assign cyc.half  = 16'((16'(tim.div) << mul_sh) >> 1);
  assign cyc.sda   = 16'(16'(tim.sda) << mul_sh);
  assign cyc.start = 16'(16'(tim.start) << mul_sh);
  assign cyc.stop  = 16'(16'(tim.stop) << mul_sh);
  assign high_tgt  = (pur_q == PUR_STOP) ? cyc.stop : cyc.half;

  // AXI4-Lite write path: address and data taken in either order
  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
  assign wr_fire       = aw_have_q && w_have_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q    <= 1'b0;
      w_have_q     <= 1'b0;
      aw_addr_q    <= '0;
      w_data_q     <= '0;
      w_strb_q     <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_q[AW-1:2] == OFS_STATUS[AW-1:2]) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      own_addr_q <= RST_OWN_ADDR;
      div_q      <= RST_DIV;
      cmd_data_q <= RST_CMD_DATA;
    end else if (wr_fire && w_strb_q[0]) begin
      if (aw_addr_q[AW-1:2] == OFS_OWN_ADDR[AW-1:2]) begin
        own_addr_q <= {w_data_q[ADDR_HI:ADDR_LO], 1'b0};
      end
      if (aw_addr_q[AW-1:2] == OFS_DIV[AW-1:2]) begin
        div_q <= w_data_q[7:0];
      end
      if (aw_addr_q[AW-1:2] == OFS_CMD[AW-1:2] && state_q inside {ST_IDLE, ST_HOLD}) begin
        cmd_data_q <= w_data_q[7:0];
      end
    end
  end

  // Commands need byte lane 1; ignored while the engine is mid-symbol
  assign go_start = wr_fire && w_strb_q[1] && aw_addr_q[AW-1:2] == OFS_CMD[AW-1:2]
                    && w_data_q[CMD_START];
  assign go_stop  = wr_fire && w_strb_q[1] && aw_addr_q[AW-1:2] == OFS_CMD[AW-1:2]
                    && w_data_q[CMD_STOP];
  assign go_send  = wr_fire && w_strb_q[1] && aw_addr_q[AW-1:2] == OFS_CMD[AW-1:2]
                    && w_data_q[CMD_SEND];

  // AXI4-Lite read path
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      unique case (s_axi_araddr[AW-1:2])
        OFS_OWN_ADDR[AW-1:2]: s_axi_rdata <= {24'h0, own_addr_q};
        OFS_DIV[AW-1:2]:      s_axi_rdata <= {24'h0, div_q};
        OFS_CMD[AW-1:2]:      s_axi_rdata <= {24'h0, cmd_data_q};
        default:              s_axi_rdata <= {27'h0, match_q, sda_s_q, scl_s_q, ack_q,
                                              state_q != ST_IDLE};
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Three-stage pin synchronisers; a level counts once the last two agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_sync_q <= 3'h7;
      sda_sync_q <= 3'h7;
      scl_s_q    <= 1'b1;
      sda_s_q    <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[1:0], scl_i};
      sda_sync_q <= {sda_sync_q[1:0], sda_i};
      if (scl_sync_q[1] == scl_sync_q[2]) begin
        scl_s_q <= scl_sync_q[2];
      end
      if (sda_sync_q[1] == sda_sync_q[2]) begin
        sda_s_q <= sda_sync_q[2];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      match_q <= 1'b0;
    end else if (rx_ten_bit) begin
      match_q <= (rx_addr[6:0] == own_addr_q[ADDR_HI:ADDR_LO]);
    end else begin
      match_q <= (rx_addr[6:0] == own_addr_q[ADDR_HI:ADDR_LO]);
    end
  end
  assign addr_match = match_q;

  // Bus timing engine; high phase counts only while the clock line is seen high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q  <= ST_IDLE;
      pur_q    <= PUR_BIT;
      cnt_q    <= '0;
      shift_q  <= '0;
      bit_q    <= '0;
      ack_q    <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (go_start) begin
            sda_oe_q <= 1'b1;
            cnt_q    <= '0;
            state_q  <= ST_START;
          end
        end
        ST_START: begin
          cnt_q <= cnt_q + 16'h1;
          if (cnt_q == cyc.start - 16'h1) begin
            scl_oe_q <= 1'b1;
            cnt_q    <= '0;
            state_q  <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          cnt_q <= '0;
          if (go_send || go_stop || go_start) begin
            pur_q   <= go_send ? PUR_BIT : (go_stop ? PUR_STOP : PUR_RSTART);
            shift_q <= {w_data_q[7:0], 1'b1};
            bit_q   <= '0;
            state_q <= ST_LOW;
          end
        end
        ST_LOW: begin
          cnt_q <= cnt_q + 16'h1;
          if (cnt_q == cyc.sda - 16'h1) begin
            unique case (pur_q)
              PUR_BIT:  sda_oe_q <= !shift_q[8];
              PUR_STOP: sda_oe_q <= 1'b1;
              default:  sda_oe_q <= 1'b0;
            endcase
          end
          if (cnt_q == cyc.half - 16'h1) begin
            scl_oe_q <= 1'b0;
            cnt_q    <= '0;
            state_q  <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          if (scl_s_q) begin
            cnt_q <= cnt_q + 16'h1;
            if (cnt_q == high_tgt - 16'h1) begin
              cnt_q <= '0;
              unique case (pur_q)
                PUR_BIT: begin
                  scl_oe_q <= 1'b1;
                  shift_q  <= {shift_q[7:0], 1'b1};
                  bit_q    <= bit_q + 4'h1;
                  state_q  <= (bit_q == 4'(ACK_BIT)) ? ST_HOLD : ST_LOW;
                  if (bit_q == 4'(ACK_BIT)) begin
                    ack_q <= !sda_s_q;
                  end
                end
                PUR_STOP: begin
                  sda_oe_q <= 1'b0;
                  state_q  <= ST_IDLE;
                end
                default: begin
                  sda_oe_q <= 1'b1;
                  state_q  <= ST_START;
                end
              endcase
            end
          end else begin
            cnt_q <= '0;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Open drain: only ever pull low
  assign scl_o  = 1'b0;
  assign sda_o  = 1'b0;
  assign scl_oe = scl_oe_q;
  assign sda_oe = sda_oe_q;

  // Helper counters for timing checks
  logic        scl_prev_q;
  logic        sda_prev_q;
  logic [15:0] since_scl_q;
  logic [15:0] since_sda_q;
  logic [15:0] scl_hi_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_prev_q  <= 1'b0;
      sda_prev_q  <= 1'b0;
      since_scl_q <= '0;
      since_sda_q <= '0;
      scl_hi_q    <= '0;
    end else begin
      scl_prev_q  <= scl_oe_q;
      sda_prev_q  <= sda_oe_q;
      since_scl_q <= (scl_oe_q != scl_prev_q) ? 16'h1 : since_scl_q + 16'h1;
      since_sda_q <= (sda_oe_q != sda_prev_q) ? 16'h1 : since_sda_q + 16'h1;
      scl_hi_q    <= scl_oe_q ? 16'h0 : (scl_s_q ? scl_hi_q + 16'h1 : scl_hi_q);
    end
  end

  sequence s_start_done;
    $past(state_q) == ST_START && state_q == ST_HOLD;
  endsequence

  AST_OD_IDLE: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == ST_IDLE |-> !scl_oe && !sda_oe && !scl_o && !sda_o)
    else $error("bus lines held while idle");
  AST_MATCH7: assert property (@(posedge aclk) disable iff (!aresetn)
    aresetn && !rx_ten_bit |=> addr_match == ($past(rx_addr[6:0]) == $past(own_addr_q[7:1])))
    else $error("7-bit address compare wrong");
  AST_MATCH10: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_ten_bit && rx_addr[6:0] != own_addr_q[7:1] ##1 $stable(own_addr_q) |-> !addr_match)
    else $error("10-bit low bits matched wrongly");
  AST_RATE_MULTIPLIER_FIELD: assert property (@(posedge aclk) disable iff (!aresetn)
    div_q[7:6] == 2'b10 |-> cyc.stop == 16'(tim.stop) * 16'd4)
    else $error("multiplier of four not applied");
  AST_TABLE: assert property (@(posedge aclk) disable iff (!aresetn)
    div_q == 8'h00 |-> tim.div == 12'd20 && tim.sda == 10'd7 && tim.start == 11'd6
      && tim.stop == 11'd11)
    else $error("code zero lookup wrong");
  AST_MIN_DIV: assert property (@(posedge aclk) disable iff (!aresetn)
    tim.div >= 12'(MIN_DIV))
    else $error("divider below twenty");
  AST_START_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    s_start_done |-> since_sda_q == cyc.start && scl_oe && sda_oe)
    else $error("start hold wrong");
  AST_DATA_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    $changed(sda_oe_q) && state_q == ST_LOW |-> cnt_q == cyc.sda && since_scl_q >= cnt_q && scl_oe)
    else $error("data hold wrong");
  AST_LOW_HALF: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(scl_oe_q) && $past(state_q) == ST_LOW
      |-> $past(cnt_q) == cyc.half - 16'h1 && since_scl_q >= cyc.half)
    else $error("low phase not half the bit period");
  AST_STOP_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(sda_oe_q) && state_q == ST_IDLE |-> scl_hi_q == cyc.stop && !scl_oe)
    else $error("stop hold wrong");
  AST_ADDR_RSV: assert property (@(posedge aclk) disable iff (!aresetn)
    !own_addr_q[0])
    else $error("reserved address bit set");

endmodule : iac_top

`default_nettype wire

// ### iac_peer.sv
// Far-side bus device: pull-ups on both lines, optional clock stretch, acknowledge.
// Assumes pin enables high mean the line is pulled low; synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module iac_peer (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic scl_oe,
  input  wire logic sda_oe,
  input  wire logic stretch,
  output logic      scl,
  output logic      sda
);
  logic       scl_q;
  logic       sda_q;
  logic [3:0] falls_q;
  logic [9:0] hold_q;
  // Wired-AND with pull-ups, so a released line reads high
  assign scl = !(scl_oe || hold_q != 10'h000);
  assign sda = !(sda_oe || falls_q == 4'h9);
  always_ff @(posedge aclk) begin
    scl_q <= scl;
    sda_q <= sda;
  end
  // Clock falls counted from start; ninth low phase is the acknowledge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      falls_q <= 4'hf;
    end else if (scl && scl_q && sda_q && !sda) begin
      falls_q <= 4'h0;
    end else if (scl_q && !scl && falls_q != 4'hf) begin
      falls_q <= falls_q + 4'h1;
    end
  end
  // Stretch outlasts the slowest low phase the testbench uses, so it is really seen
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_q <= 10'h000;
    end else if (scl_q && !scl && stretch) begin
      hold_q <= 10'h258;
    end else if (hold_q != 10'h000) begin
      hold_q <= hold_q - 10'h001;
    end
  end
endmodule : iac_peer
`default_nettype wire

// ### tb.sv
// Testbench: AXI4-Lite register access and measured bus timing per rate setting.
// Assumes iac_top and iac_peer; 40 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import iac_pkg::*;
  logic aclk, aresetn, awv, wv, bv, bvr, arv, rv, rvr, awr, wr, arr, ten, am;
  logic scl, sda, scl_oe, sda_oe, stretch, scl_d, sclo, sdao;
  logic [3:0] awa, ara;
  logic [31:0] wd, rd;
  logic [1:0] br, rr;
  logic [9:0] rxa;
  logic [8:0] cap;
  int n_errors, samples_checked, nrise, nbase;
  iac_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bvr),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rvr), .rx_addr(rxa),
    .rx_ten_bit(ten), .addr_match(am), .scl_i(scl), .scl_o(sclo), .scl_oe(scl_oe),
    .sda_i(sda), .sda_o(sdao), .sda_oe(sda_oe));
  iac_peer peer (.aclk(aclk), .aresetn(aresetn), .scl_oe(scl_oe), .sda_oe(sda_oe),
    .stretch(stretch), .scl(scl), .sda(sda));
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = !aclk;
  end
  // Bits seen on the wire at each clock rise
  always @(posedge aclk) begin
    scl_d <= scl;
    if (scl && !scl_d) begin
      cap <= {cap[7:0], sda};
      nrise <= nrise + 1;
    end
  end
  task automatic test_done;
    $display("Errors %0d, checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bvr <= 1'b1;
    do begin
      @(posedge aclk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
    end while (!(bvr && bv));
    r = br;
  endtask : axw
  task automatic axr(input logic [3:0] a, output logic [31:0] d);
    ara <= a;
    arv <= 1'b1;
    rvr <= 1'b1;
    do begin
      @(posedge aclk);
      if (arv && arr) arv <= 1'b0;
    end while (!(rvr && rv));
    d = rd;
  endtask : axr
  function automatic logic sig(input int s);
    case (s)
      0: return scl_oe;
      1: return sda_oe;
      2: return scl;
      3: return nrise >= nbase + 1;
      default: return nrise >= nbase + 9;
    endcase
  endfunction : sig
  // Edges until the watched level is first sampled
  task automatic wt(input int s, input logic v, output int n);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (sig(s) !== v);
  endtask : wt
  initial begin
    #2_500_000;
    n_errors++;
    test_done();
  end
  initial begin
    logic [1:0] r;
    logic [31:0] d;
    int n, ns, mul;
    int cfg[3][6] = '{'{0, 8'h00, 20, 7, 6, 11}, '{1, 8'h07, 40, 10, 16, 21},
                      '{2, 8'h1f, 240, 33, 118, 121}};
    {awv, wv, bvr, arv, rvr, ten, stretch} = '0;
    {awa, ara, wd, rxa, cap} = '0;
    aresetn = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axr(OFS_OWN_ADDR, d); chk(d, 32'h0);
    axr(OFS_DIV, d); chk(d, 32'h0); chk(32'(rr), 32'(RESP_OKAY));
    chk(32'({sclo, sdao}), 32'h0);
    axw(OFS_OWN_ADDR, 32'hb5, r); chk(32'(r), 32'(RESP_OKAY));
    axr(OFS_OWN_ADDR, d); chk(d, 32'hb4);
    axw(OFS_STATUS, 32'h1f, r); chk(32'(r), 32'(RESP_SLVERR));
    rxa <= 10'h05a; repeat (3) @(posedge aclk); chk(32'(am), 32'h1);
    rxa <= 10'h05b; repeat (3) @(posedge aclk); chk(32'(am), 32'h0);
    ten <= 1'b1; rxa <= 10'h35a; repeat (3) @(posedge aclk); chk(32'(am), 32'h1);
    rxa <= 10'h35b; repeat (3) @(posedge aclk); chk(32'(am), 32'h0);
    for (int i = 0; i < 3; i++) begin
      mul = 1 << cfg[i][0];
      stretch <= (i == 2);
      axw(OFS_DIV, 32'(cfg[i][0] * 64 + cfg[i][1]), r);
      axr(OFS_DIV, d); chk(d, 32'(cfg[i][0] * 64 + cfg[i][1]));
      fork
        axw(OFS_CMD, 32'h100, r);
        begin
          wt(1, 1'b1, n);
          wt(0, 1'b1, n);
          chk(32'(n), 32'(mul * cfg[i][4]));
        end
      join
      nbase = nrise;
      fork
        axw(OFS_CMD, 32'h4a5, r);
        begin
          wt(3, 1'b1, n);
          wt(0, 1'b1, n);
          n = 0;
          ns = 0;
          while (scl_oe) begin
            @(posedge aclk);
            n++;
            if (sda_oe && ns == 0) ns = n;
          end
          chk(32'(ns), 32'(mul * cfg[i][3]));
          chk(32'(n), 32'(mul * cfg[i][2] / 2));
        end
      join
      wt(4, 1'b1, n);
      wt(0, 1'b1, n);
      chk({23'h0, cap}, {23'h0, 8'ha5, 1'b0});
      axr(OFS_STATUS, d); chk(d & 32'h3, 32'h3);
      // Repeated start from the hold state
      fork
        axw(OFS_CMD, 32'h100, r);
        begin
          wt(2, 1'b1, n);
          wt(1, 1'b1, n);
          wt(0, 1'b1, n);
          chk(32'(n), 32'(mul * cfg[i][4]));
        end
      join
      fork
        axw(OFS_CMD, 32'h200, r);
        begin
          wt(2, 1'b1, n);
          wt(1, 1'b0, n);
          // Sensed clock lags the wire by the synchroniser depth
          chk(32'(n >= mul * cfg[i][5] && n <= mul * cfg[i][5] + 5), 32'h1);
        end
      join
      repeat (8) @(posedge aclk);
      axr(OFS_STATUS, d); chk(d & 32'h1f, 32'h0e);
    end
    test_done();
  end
endmodule : tb
`default_nettype wire
